// File: hw/tbi_burst_indicator.sv
`timescale 1ns/1ps
`include "tbi_regs.svh"

module tbi_burst_indicator #(
  parameter int FRAME_CYC = `TBI_FRAME_CYC,
  parameter int ADVANCE_CYC = `TBI_ADVANCE_CYC,
  parameter int SLOT_CYC = `TBI_SLOT_CYC,
  parameter int DELAY_CYC = `TBI_DELAY_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // scheduler request, sampled at each frame boundary
  input tbi_pkg::tbi_request_type txRequest,
  // status pins
  output logic txBurstIndicator_reg,
  output logic txSlotGate_reg
);

  // =====================================================================
  // frame timer
  logic [`TBI_CNT_W-1:0] frameCnt_reg;
  logic [`TBI_CNT_W-1:0] frameCnt_next;
  wire frameTick = (frameCnt_reg == `TBI_CNT_W'(FRAME_CYC - 1));

  assign frameCnt_next = frameTick ? '0 : frameCnt_reg + `TBI_CNT_W'(1);

  // =====================================================================
  // burst sequencer
  tbi_pkg::tbi_state_type state_reg;
  tbi_pkg::tbi_state_type state_next;
  logic [`TBI_CNT_W-1:0] phaseCnt_reg;
  logic [`TBI_CNT_W-1:0] phaseCnt_next;
  logic [`TBI_SLOT_W-1:0] slots_reg;
  logic [`TBI_SLOT_W-1:0] slots_next;

  wire [`TBI_SLOT_W-1:0] reqSlots = tbi_pkg::clampSlots(txRequest.slots);
  wire startBurst = frameTick && txRequest.enable && (reqSlots != '0);
  wire phaseDone = (phaseCnt_reg == '0);
  wire [`TBI_CNT_W-1:0] slotLoad = tbi_pkg::slotSpan(slots_reg, SLOT_CYC) - `TBI_CNT_W'(1);
  // a zero trailing delay ends the burst with the last slot
  wire zeroTrail = (DELAY_CYC == 0);

  always_comb
  begin
    state_next = state_reg;
    phaseCnt_next = phaseDone ? phaseCnt_reg : phaseCnt_reg - `TBI_CNT_W'(1);
    slots_next = slots_reg;
    unique case (state_reg)
      tbi_pkg::TBI_IDLE:
      begin
        if (startBurst)
        begin
          state_next = tbi_pkg::TBI_ADVANCE;
          phaseCnt_next = `TBI_CNT_W'(ADVANCE_CYC - 1);
          slots_next = reqSlots;
        end
      end
      tbi_pkg::TBI_ADVANCE:
      begin
        if (phaseDone)
        begin
          state_next = tbi_pkg::TBI_SLOTS;
          phaseCnt_next = slotLoad;
        end
      end
      tbi_pkg::TBI_SLOTS:
      begin
        if (phaseDone)
        begin
          state_next = zeroTrail ? tbi_pkg::TBI_IDLE : tbi_pkg::TBI_TRAIL;
          phaseCnt_next = zeroTrail ? '0 : `TBI_CNT_W'(DELAY_CYC - 1);
        end
      end
      tbi_pkg::TBI_TRAIL:
      begin
        if (phaseDone)
        begin
          state_next = tbi_pkg::TBI_IDLE;
        end
      end
    endcase
  end

  wire indicatorNext = (state_next != tbi_pkg::TBI_IDLE);
  wire slotGateNext = (state_next == tbi_pkg::TBI_SLOTS);

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      frameCnt_reg <= '0;
      state_reg <= tbi_pkg::TBI_IDLE;
      phaseCnt_reg <= '0;
      slots_reg <= '0;
      txBurstIndicator_reg <= 1'b0;
      txSlotGate_reg <= 1'b0;
    end
    else
    begin
      frameCnt_reg <= frameCnt_next;
      state_reg <= state_next;
      phaseCnt_reg <= phaseCnt_next;
      slots_reg <= slots_next;
      txBurstIndicator_reg <= indicatorNext;
      txSlotGate_reg <= slotGateNext;
    end
  end

  // =====================================================================
  // checks; helper counters measure phase lengths
  logic [`TBI_CNT_W-1:0] highLen;
  logic [`TBI_CNT_W-1:0] trailLen;
  logic [`TBI_CNT_W-1:0] gateLen;
  logic seenTick;
  wire [`TBI_CNT_W-1:0] slotSpanNow = tbi_pkg::slotSpan(slots_reg, SLOT_CYC);
  wire [`TBI_CNT_W-1:0] expectSpan = `TBI_CNT_W'(ADVANCE_CYC + DELAY_CYC) + slotSpanNow;
  // past the advance with the gate low can only be the trailing delay
  wire inTrail = txBurstIndicator_reg && !txSlotGate_reg
                 && (highLen > `TBI_CNT_W'(ADVANCE_CYC));
  wire zeroSlotAsk = frameTick && txRequest.enable && (txRequest.slots == '0);
  wire clampAsk = frameTick && txRequest.enable && (txRequest.slots > `TBI_MAX_SLOTS);

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      highLen <= '0;
    end
    else
    begin
      highLen <= txBurstIndicator_reg ? highLen + `TBI_CNT_W'(1) : '0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      trailLen <= '0;
    end
    else
    begin
      trailLen <= inTrail ? trailLen + `TBI_CNT_W'(1) : '0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gateLen <= '0;
    end
    else
    begin
      gateLen <= txSlotGate_reg ? gateLen + `TBI_CNT_W'(1) : '0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      seenTick <= 1'b0;
    end
    else
    begin
      seenTick <= seenTick | frameTick;
    end
  end

  // =====================================================================
  // rule checks
  reset_low_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !seenTick |-> !txBurstIndicator_reg)
    else $error("indicator high before first burst");

  frame_start_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(txBurstIndicator_reg) |-> $past(frameTick))
    else $error("burst did not start on a frame boundary");

  burst_span_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $fell(txBurstIndicator_reg) |-> highLen == expectSpan)
    else $error("indicator high span wrong");

  gate_len_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $fell(txSlotGate_reg) |-> gateLen == slotSpanNow)
    else $error("slotted portion length wrong");

  slots_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (txBurstIndicator_reg && !$rose(txBurstIndicator_reg)) |-> $stable(slots_reg))
    else $error("slot count changed inside a burst");

  advance_len_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(txSlotGate_reg) |-> highLen == `TBI_CNT_W'(ADVANCE_CYC))
    else $error("advance interval wrong");

  trail_len_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $fell(txBurstIndicator_reg) |-> trailLen == `TBI_CNT_W'(DELAY_CYC))
    else $error("trailing delay wrong");

  trail_bound_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    inTrail |-> trailLen < `TBI_CNT_W'(DELAY_CYC))
    else $error("trailing delay overran");

  gate_inside_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    txSlotGate_reg |-> txBurstIndicator_reg)
    else $error("slots active while indicator low");

  idle_frame_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (frameTick && !txRequest.enable && !txBurstIndicator_reg) |=> !txBurstIndicator_reg)
    else $error("burst without request");

  zero_slot_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (zeroSlotAsk && !txBurstIndicator_reg) |=> !txBurstIndicator_reg)
    else $error("burst for a zero slot request");

  // =====================================================================
  // scenario covers
  burst_seen_c: cover property (@(posedge sys_clk) disable iff (!rst_n)
    $fell(txBurstIndicator_reg));
  max_slots_c: cover property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(txSlotGate_reg) && slots_reg == `TBI_MAX_SLOTS);
  skip_frame_c: cover property (@(posedge sys_clk) disable iff (!rst_n)
    frameTick && !txRequest.enable && seenTick);
  zero_slot_c: cover property (@(posedge sys_clk) disable iff (!rst_n)
    zeroSlotAsk && !txBurstIndicator_reg);
  clamp_ask_c: cover property (@(posedge sys_clk) disable iff (!rst_n)
    clampAsk && !txBurstIndicator_reg);

endmodule // tbi_burst_indicator

// File: hw/tbi_pkg.sv
`include "tbi_regs.svh"

package tbi_pkg;

  // per-frame request from the radio scheduler
  typedef struct packed {
    logic enable;
    logic [`TBI_SLOT_W-1:0] slots;
  } tbi_request_type;

  typedef enum logic [3:0] {
    TBI_IDLE = 4'h1,
    TBI_ADVANCE = 4'h2,
    TBI_SLOTS = 4'h4,
    TBI_TRAIL = 4'h8
  } tbi_state_type;

  // slots clamped to the supported uplink maximum
  function automatic logic [`TBI_SLOT_W-1:0] clampSlots(input logic [`TBI_SLOT_W-1:0] s);
    clampSlots = (s > `TBI_MAX_SLOTS) ? `TBI_MAX_SLOTS : s;
  endfunction

  function automatic logic [`TBI_CNT_W-1:0] slotSpan(input logic [`TBI_SLOT_W-1:0] s,
                                                   input int slotCyc);
    slotSpan = `TBI_CNT_W'(int'(s) * slotCyc);
  endfunction

endpackage

// File: hw/tbi_regs.svh
// Behaviour
// - indicator high during burst, low otherwise
// - bursts recur at about 217 Hz
// - high span grows 0.577 ms per slot
// - rises 240 us ahead, never under 240
// - stays high 0 to 30 us after slots
`ifndef TBI_REGS_SVH
`define TBI_REGS_SVH

// =====================================================================
// clock
`define TBI_CLK_HZ 40000000
`define TBI_CLK_PERIOD_NS 25

// =====================================================================
// burst timing, figures in their own units
`define TBI_FRAME_RATE_HZ 217
`define TBI_ADVANCE_NS 240000
`define TBI_SLOT_NS 577000
`define TBI_DELAY_NS 30000

// =====================================================================
// derived cycle counts (least times round up, longest round down)
`define TBI_FRAME_CYC (`TBI_CLK_HZ / `TBI_FRAME_RATE_HZ)
`define TBI_ADVANCE_CYC ((`TBI_ADVANCE_NS + `TBI_CLK_PERIOD_NS - 1) / `TBI_CLK_PERIOD_NS)
`define TBI_SLOT_CYC (`TBI_SLOT_NS / `TBI_CLK_PERIOD_NS)
`define TBI_DELAY_CYC (`TBI_DELAY_NS / `TBI_CLK_PERIOD_NS)

// =====================================================================
// widths and limits
`define TBI_CNT_W 18
`define TBI_SLOT_W 3
`define TBI_MAX_SLOTS 3'h4

`endif

// File: verification/tbi_host_monitor.sv
`timescale 1ns/1ps
// =====================================================================
// host side: measures burst width, slot gate width (all slots together) and burst spacing
module tbi_host_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // watched pins
  input wire logic ind,
  input wire logic gate,
  // measured cycle counts
  output logic [17:0] highLen,
  output logic [17:0] gateLen,
  output logic [17:0] gap
);
  logic indPrev_reg;
  logic gatePrev_reg;
  logic [17:0] hc_reg;
  logic [17:0] gc_reg;
  logic [17:0] pc_reg;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      {indPrev_reg, gatePrev_reg, hc_reg, gc_reg, pc_reg} <= '0;
      {highLen, gateLen, gap} <= '0;
    end
    else
    begin
      indPrev_reg <= ind;
      gatePrev_reg <= gate;
      hc_reg <= ind ? hc_reg + 18'h1 : 18'h0;
      gc_reg <= gate ? gc_reg + 18'h1 : 18'h0;
      pc_reg <= (ind && !indPrev_reg) ? 18'h1 : pc_reg + 18'h1;
      if (!ind && indPrev_reg) highLen <= hc_reg;
      if (!gate && gatePrev_reg) gateLen <= gc_reg;
      if (ind && !indPrev_reg) gap <= pc_reg;
    end
  end
endmodule // tbi_host_monitor

// File: verification/testbench.sv
`timescale 1ns/1ps
module testbench;
  // short counts keep the run small; a burst of 4 slots still fits a frame
  localparam int FR = 200, AD = 10, SL = 20, DL = 5;
  logic sysClk = 1'b0;
  logic rst_n = 1'b0;
  tbi_pkg::tbi_request_type req = '0;
  logic ind, gate, hit, prevHit;
  logic [17:0] highLen, gateLen, gap;
  logic [31:0] seed = 32'hCCD0B06F;
  int errors = 0, cmpCount = 0;
  always #12.5 sysClk = ~sysClk;
  tbi_burst_indicator #(.FRAME_CYC(FR), .ADVANCE_CYC(AD), .SLOT_CYC(SL), .DELAY_CYC(DL))
    u_tbi_burst_indicator (.sys_clk(sysClk), .rst_n(rst_n), .txRequest(req),
    .txBurstIndicator_reg(ind), .txSlotGate_reg(gate));
  tbi_host_monitor u_tbi_host_monitor (.clk(sysClk), .rst_n(rst_n), .ind(ind),
    .gate(gate), .highLen(highLen), .gateLen(gateLen), .gap(gap));
  // =====================================================================
  // expectations
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic int slotsOf(input tbi_pkg::tbi_request_type r);
    return !r.enable ? 0 : (r.slots > 3'h4 ? 4 : int'(r.slots));
  endfunction
  // =====================================================================
  // checking and closing
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    cmpCount++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("errors=%0d comparisons=%0d", errors, cmpCount);
    if (errors == 0 && cmpCount > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic waitInd(input logic v);
    int n;
    n = 0;
    while (ind !== v && n < 2 * FR)
    begin
      @(posedge sysClk);
      #2;
      n++;
    end
    chk({17'h0, ind}, {17'h0, v});
  endtask
  task automatic quietFrame;
    hit = 1'b0;
    repeat (FR + 10)
    begin
      @(posedge sysClk);
      #2;
      hit |= ind;
    end
  endtask
  // =====================================================================
  // main sequence: corner requests first, then random ones
  initial
  begin
    tbi_pkg::tbi_request_type corner[6];
    tbi_pkg::tbi_request_type r;
    int s;
    corner = '{4'h9, 4'hC, 4'hF, 4'h8, 4'h3, 4'hA};
    req = corner[0];
    repeat (5) @(posedge sysClk);
    #2 rst_n = 1'b1;
    hit = 1'b0;
    repeat (FR - 3)
    begin
      @(posedge sysClk);
      #2;
      hit |= ind;
    end
    chk({17'h0, hit}, 18'h0);
    prevHit = 1'b0;
    for (int i = 0; i < 16; i++)
    begin
      seed = xorshift(seed);
      r = (i < 6) ? corner[i] : seed[3:0];
      req = r;
      s = slotsOf(r);
      if (s == 0)
      begin
        quietFrame();
        chk({17'h0, hit}, 18'h0);
        prevHit = 1'b0;
      end
      else
      begin
        waitInd(1'b1);
        waitInd(1'b0);
        @(posedge sysClk);
        #2;
        chk(highLen, 18'(AD + s * SL + DL));
        chk(gateLen, 18'(s * SL));
        if (prevHit) chk(gap, 18'(FR));
        prevHit = 1'b1;
      end
    end
    end_sim();
  end
  initial
  begin
    #(25 * FR * 40);
    errors++;
    end_sim();
  end
endmodule // testbench
